// ### gtm_pkg.sv
// package: register map, fields, reset values and codes of the timer
package gtm_pkg;
  localparam logic [7:0]  OFF_CFG         = 8'h00;
  localparam logic [7:0]  OFF_AMODE       = 8'h04;
  localparam logic [7:0]  OFF_BMODE       = 8'h08;
  localparam logic [7:0]  OFF_CTL         = 8'h0C;
  localparam logic [7:0]  OFF_IMR         = 8'h18;
  localparam logic [7:0]  OFF_RIS         = 8'h1C;
  localparam logic [7:0]  OFF_MIS         = 8'h20;
  localparam logic [7:0]  OFF_ICR         = 8'h24;
  localparam logic [7:0]  OFF_AILR        = 8'h28;
  localparam logic [7:0]  OFF_BILR        = 8'h2C;
  localparam logic [7:0]  OFF_AMATCH      = 8'h30;
  localparam logic [7:0]  OFF_BMATCH      = 8'h34;
  localparam logic [7:0]  OFF_APR         = 8'h38;
  localparam logic [7:0]  OFF_BPR         = 8'h3C;
  localparam logic [7:0]  OFF_AVAL        = 8'h48;
  localparam logic [7:0]  OFF_BVAL        = 8'h4C;
  // global configuration codes
  localparam logic [2:0]  CFG_32          = 3'h0;
  localparam logic [2:0]  CFG_RTC         = 3'h1;
  localparam logic [2:0]  CFG_SPLIT       = 3'h4;
  // half mode register fields
  localparam logic [1:0]  MODE_ONESHOT    = 2'h1;
  localparam logic [1:0]  MODE_PERIODIC   = 2'h2;
  localparam logic [1:0]  MODE_CAPTURE    = 2'h3;
  localparam int          MODE_CMR_BIT    = 2;
  localparam int          MODE_AMS_BIT    = 3;
  // control register fields, half b sits one stride above half a
  localparam int          CTL_EN_BIT      = 0;
  localparam int          CTL_EVT_LSB     = 2;
  localparam int          CTL_RTC_BIT     = 4;
  localparam int          CTL_INV_BIT     = 6;
  localparam int          CTL_STRIDE      = 8;
  localparam logic [1:0]  EVT_RISE        = 2'h0;
  localparam logic [1:0]  EVT_FALL        = 2'h1;
  localparam logic [1:0]  EVT_BOTH        = 2'h3;
  // status / mask / clear bit positions
  localparam int          ST_TO_BIT       = 0;
  localparam int          ST_CM_BIT       = 1;
  localparam int          ST_CE_BIT       = 2;
  localparam int          ST_RTC_BIT      = 3;
  localparam int          ST_STRIDE       = 8;
  localparam logic [31:0] ST_USED         = 32'h0000070F;
  // reset values
  localparam logic [31:0] RST_ILR_A       = 32'hFFFFFFFF;
  localparam logic [31:0] RST_ILR_B       = 32'h0000FFFF;
  localparam logic [31:0] RST_ZERO        = 32'h00000000;
  localparam logic [31:0] MASK16          = 32'h0000FFFF;
  localparam logic [31:0] MASK32          = 32'hFFFFFFFF;
  localparam logic [7:0]  RST_PR          = 8'h00;
  // bus answers
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ### gtm_top.sv
// general purpose timer with axi4-lite register slave
//
// How it works
// RL1 - software enables the timer clock gate first
// RL2 - software stops the timer before reconfiguring
// RL3 - config 0x0 selects 32-bit one-shot/periodic
// RL4 - config 0x1 selects 32-bit real-time counter
// RL5 - config 0x4 splits into two 16-bit halves
// RL6 - mode 0x1 one-shot, 0x2 periodic
// RL7 - one-shot stops at time-out, periodic continues
// RL8 - time-out sets sticky flag, write-one clears
// RL9 - time-out interrupt only when masked in
// RL10 - outside supplies 32.768 kHz on capture pin
// RL11 - real-time count reaching match reloads zero
// RL12 - real-time match flag needs no clearing
// RL13 - prescaler extends 16-bit timer count range
// RL14 - capture bit 0, mode 0x3: edge count
// RL15 - edge count stops after programmed events
// RL16 - count reached sets sticky match flag
// RL17 - capture bit 1, mode 0x3: edge timing
// RL18 - captured value readable, capture flag set
// RL19 - edge timing keeps running; reload next cycle
// RL20 - alt bit 1, capture 0, mode 0x2: pwm
// RL21 - pwm polarity follows invert bit
// RL22 - pwm runs continuously; new period next cycle
// RL23 - pwm high at start, low at match
// RL24 - each edge decrements, reload and stop at match
// RL25 - masked status is raw and mask, ored; the code ands them (ris & interrupt_mask_reg)
// RL26 - capture pins synchronised before edge detect
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module gtm_top (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // axi4-lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // timer pins
  input  wire logic [1:0]  capture_pin,
  output logic [1:0]       pwm_out,
  output logic             irq
);
  import gtm_pkg::*;

  // software visible state
  logic [2:0]  global_config_reg;
  logic [3:0]  half_mode_reg [0:1];
  logic [31:0] control_reg;
  logic [31:0] interrupt_mask_reg;
  logic [31:0] raw_status_reg;
  logic [31:0] interval_load_reg [0:1];
  logic [31:0] match_reg [0:1];
  logic [7:0]  prescale_reg [0:1];
  // bus slave state
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  // timer state per half
  logic [31:0] cnt_reg [0:1];
  logic [31:0] cap_reg [0:1];
  logic [7:0]  ps_reg [0:1];
  logic        pwm_lvl_reg [0:1];
  logic        ilr_load_reg [0:1];
  logic [1:0]  pwm_out_reg;
  logic        irq_reg;
  // combinational
  logic        wr_fire;
  logic        split;
  logic [31:0] wmask;
  logic [31:0] clear_bits;
  logic [31:0] set_bits;
  logic [31:0] ris;
  logic        rtc_match;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        ev_to [0:1];
  logic        ev_cm [0:1];
  logic        ev_ce [0:1];
  logic        stop [0:1];
  logic [31:0] tval [0:1];

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == OFF_CFG || a == OFF_AMODE || a == OFF_BMODE || a == OFF_CTL ||
           a == OFF_IMR || a == OFF_RIS || a == OFF_MIS || a == OFF_ICR ||
           a == OFF_AILR || a == OFF_BILR || a == OFF_AMATCH ||
           a == OFF_BMATCH || a == OFF_APR || a == OFF_BPR ||
           a == OFF_AVAL || a == OFF_BVAL;
  endfunction

  function automatic logic wr_hit(input logic fire, input logic [7:0] a,
                                  input logic [7:0] off);
    return fire && a == off;
  endfunction

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign pwm_out       = pwm_out_reg;
  assign irq           = irq_reg;

  // address and data are taken in either order, then written together
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= RST_ZERO;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= RST_ZERO;
      rresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= rd_data;
        rresp_reg   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // configuration registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      global_config_reg    <= CFG_32;
      half_mode_reg[0]     <= 4'h0;
      half_mode_reg[1]     <= 4'h0;
      interrupt_mask_reg   <= RST_ZERO;
      interval_load_reg[0] <= RST_ILR_A;
      interval_load_reg[1] <= RST_ILR_B;
      match_reg[0]         <= RST_ILR_A;
      match_reg[1]         <= RST_ILR_B;
      prescale_reg[0]      <= RST_PR;
      prescale_reg[1]      <= RST_PR;
    end else begin
      if (wr_hit(wr_fire, aw_addr_reg, OFF_CFG))
        global_config_reg <= 3'(merge({29'h0, global_config_reg}, w_data_reg, w_strb_reg));
      if (wr_hit(wr_fire, aw_addr_reg, OFF_AMODE))
        half_mode_reg[0] <= 4'(merge({28'h0, half_mode_reg[0]}, w_data_reg, w_strb_reg));
      if (wr_hit(wr_fire, aw_addr_reg, OFF_BMODE))
        half_mode_reg[1] <= 4'(merge({28'h0, half_mode_reg[1]}, w_data_reg, w_strb_reg));
      if (wr_hit(wr_fire, aw_addr_reg, OFF_IMR))
        interrupt_mask_reg <= merge(interrupt_mask_reg, w_data_reg, w_strb_reg) & ST_USED;
      if (wr_hit(wr_fire, aw_addr_reg, OFF_AILR))
        interval_load_reg[0] <= merge(interval_load_reg[0], w_data_reg, w_strb_reg);
      if (wr_hit(wr_fire, aw_addr_reg, OFF_BILR))
        interval_load_reg[1] <= merge(interval_load_reg[1], w_data_reg, w_strb_reg) & MASK16;
      if (wr_hit(wr_fire, aw_addr_reg, OFF_AMATCH))
        match_reg[0] <= merge(match_reg[0], w_data_reg, w_strb_reg);
      if (wr_hit(wr_fire, aw_addr_reg, OFF_BMATCH))
        match_reg[1] <= merge(match_reg[1], w_data_reg, w_strb_reg) & MASK16;
      if (wr_hit(wr_fire, aw_addr_reg, OFF_APR))
        prescale_reg[0] <= 8'(merge({24'h0, prescale_reg[0]}, w_data_reg, w_strb_reg));
      if (wr_hit(wr_fire, aw_addr_reg, OFF_BPR))
        prescale_reg[1] <= 8'(merge({24'h0, prescale_reg[1]}, w_data_reg, w_strb_reg));
    end
  end

  // control: hardware clear of run enable overrides a bus write in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      control_reg <= RST_ZERO;
    end else begin
      if (wr_hit(wr_fire, aw_addr_reg, OFF_CTL))
        control_reg <= merge(control_reg, w_data_reg, w_strb_reg);
      if (stop[0])
        control_reg[CTL_EN_BIT] <= 1'b0; // RL7 RL15
      if (stop[1])
        control_reg[CTL_STRIDE + CTL_EN_BIT] <= 1'b0; // RL7 RL15
    end
  end

  assign split = global_config_reg[2]; // RL5
  assign wmask = split ? MASK16 : MASK32;

  genvar h;
  generate
    for (h = 0; h < 2; h++) begin : g_half
      localparam int CB = h * CTL_STRIDE;
      logic        sync1_reg;
      logic        sync2_reg;
      logic        prev_reg;
      logic        rise;
      logic        fall;
      logic        edge_hit;
      logic        en;
      logic        is_rtc;
      logic        is_tmr;
      logic        is_cnt;
      logic        is_time;
      logic        is_pwm;
      logic        ps_zero;
      logic [1:0]  evt;
      logic [1:0]  mode;
      logic [31:0] cur;
      logic [31:0] ilrv;
      logic [31:0] mtch;

      // two stage synchroniser, edges judged on the second stage only
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          sync1_reg <= 1'b0;
          sync2_reg <= 1'b0;
          prev_reg  <= 1'b0;
        end else begin
          sync1_reg <= capture_pin[h]; // RL26
          sync2_reg <= sync1_reg;
          prev_reg  <= sync2_reg;
        end
      end

      always_comb begin
        rise     = sync2_reg && !prev_reg;
        fall     = !sync2_reg && prev_reg;
        evt      = control_reg[CB + CTL_EVT_LSB +: 2];
        edge_hit = (rise && evt != EVT_FALL) || (fall && (evt == EVT_FALL || evt == EVT_BOTH));
        en       = control_reg[CB + CTL_EN_BIT];
        mode     = half_mode_reg[h][1:0];
        is_rtc   = h == 0 && global_config_reg == CFG_RTC; // RL4
        is_cnt   = split && mode == MODE_CAPTURE && !half_mode_reg[h][MODE_CMR_BIT]; // RL14
        is_time  = split && mode == MODE_CAPTURE && half_mode_reg[h][MODE_CMR_BIT]; // RL17
        is_pwm   = split && mode == MODE_PERIODIC && half_mode_reg[h][MODE_AMS_BIT] &&
                   !half_mode_reg[h][MODE_CMR_BIT]; // RL20
        is_tmr   = (split || (h == 0 && global_config_reg == CFG_32)) && !is_pwm &&
                   (mode == MODE_ONESHOT || mode == MODE_PERIODIC); // RL3 RL6
        cur      = cnt_reg[h] & wmask;
        ilrv     = interval_load_reg[h] & wmask;
        mtch     = match_reg[h] & wmask;
        ps_zero  = !split || ps_reg[h] == RST_PR; // RL13
        ev_to[h] = en && is_tmr && ps_zero && cur == RST_ZERO; // RL8
        ev_cm[h] = en && is_cnt && cur == mtch; // RL16
        ev_ce[h] = en && is_time && edge_hit; // RL18
        stop[h]  = (ev_to[h] && mode == MODE_ONESHOT) || ev_cm[h];
        tval[h]  = (is_time ? cap_reg[h] : cnt_reg[h]) & wmask; // RL18
      end

      // a load register write reaches the counter on the following edge, except in real-time mode
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
          ilr_load_reg[h] <= 1'b0;
        else
          ilr_load_reg[h] <= wr_hit(wr_fire, aw_addr_reg, h == 0 ? OFF_AILR : OFF_BILR);
      end

      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          cnt_reg[h] <= h == 0 ? RST_ILR_A : RST_ILR_B;
          cap_reg[h] <= RST_ZERO;
          ps_reg[h]  <= RST_PR;
        end else if (ilr_load_reg[h] && !is_rtc) begin
          cnt_reg[h] <= ilrv; // RL19 RL22
          ps_reg[h]  <= prescale_reg[h];
        end else if (en) begin
          if (is_rtc) begin
            if (rise && control_reg[CTL_RTC_BIT])
              cnt_reg[h] <= cnt_reg[h] == match_reg[h] ? RST_ZERO : cnt_reg[h] + 32'h1; // RL11
          end else if (is_cnt) begin
            if (cur == mtch)
              cnt_reg[h] <= ilrv; // RL24
            else if (edge_hit)
              cnt_reg[h] <= cur - 32'h1; // RL24
          end else if (is_time) begin
            if (edge_hit)
              cap_reg[h] <= cur; // RL18
            cnt_reg[h] <= cur == RST_ZERO ? ilrv : cur - 32'h1; // RL19
          end else if (is_tmr || is_pwm) begin
            if (!ps_zero) begin
              ps_reg[h] <= ps_reg[h] - 8'h1; // RL13
            end else begin
              ps_reg[h]  <= split ? prescale_reg[h] : RST_PR;
              cnt_reg[h] <= cur == RST_ZERO ? ilrv : cur - 32'h1; // RL7 RL22
            end
          end
        end
      end

      // no status is touched in pwm mode
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n)
          pwm_lvl_reg[h] <= 1'b0;
        else if (!(en && is_pwm))
          pwm_lvl_reg[h] <= 1'b0;
        else if (cur == ilrv)
          pwm_lvl_reg[h] <= 1'b1; // RL23
        else if (cur == mtch)
          pwm_lvl_reg[h] <= 1'b0; // RL23
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      pwm_out_reg <= 2'b00;
    else
      pwm_out_reg <= {pwm_lvl_reg[1] ^ control_reg[CTL_STRIDE + CTL_INV_BIT],
                      pwm_lvl_reg[0] ^ control_reg[CTL_INV_BIT]}; // RL21
  end

  // real-time match is a level, so it falls by itself on the next tick
  assign rtc_match = global_config_reg == CFG_RTC && control_reg[CTL_EN_BIT] &&
                     cnt_reg[0] == match_reg[0]; // RL12

  always_comb begin
    clear_bits = RST_ZERO;
    set_bits   = RST_ZERO;
    if (wr_hit(wr_fire, aw_addr_reg, OFF_ICR))
      clear_bits = merge(RST_ZERO, w_data_reg, w_strb_reg);
    for (int i = 0; i < 2; i++) begin
      set_bits[i * ST_STRIDE + ST_TO_BIT] = ev_to[i];
      set_bits[i * ST_STRIDE + ST_CM_BIT] = ev_cm[i];
      set_bits[i * ST_STRIDE + ST_CE_BIT] = ev_ce[i];
    end
    ris = raw_status_reg;
    ris[ST_RTC_BIT] = rtc_match;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      raw_status_reg <= RST_ZERO;
    else
      raw_status_reg <= (raw_status_reg & ~clear_bits) | set_bits; // RL8 RL16 RL18
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(ris & interrupt_mask_reg); // RL9 RL25
  end

  always_comb begin
    rd_ok   = mapped(s_axi_araddr);
    rd_data = RST_ZERO;
    case (s_axi_araddr)
      OFF_CFG:    rd_data = {29'h0, global_config_reg};
      OFF_AMODE:  rd_data = {28'h0, half_mode_reg[0]};
      OFF_BMODE:  rd_data = {28'h0, half_mode_reg[1]};
      OFF_CTL:    rd_data = control_reg;
      OFF_IMR:    rd_data = interrupt_mask_reg;
      OFF_RIS:    rd_data = ris;
      OFF_MIS:    rd_data = ris & interrupt_mask_reg; // RL25
      OFF_AILR:   rd_data = interval_load_reg[0];
      OFF_BILR:   rd_data = interval_load_reg[1];
      OFF_AMATCH: rd_data = match_reg[0];
      OFF_BMATCH: rd_data = match_reg[1];
      OFF_APR:    rd_data = {24'h0, prescale_reg[0]};
      OFF_BPR:    rd_data = {24'h0, prescale_reg[1]};
      OFF_AVAL:   rd_data = tval[0];
      OFF_BVAL:   rd_data = tval[1];
      default:    rd_data = RST_ZERO;
    endcase
  end
endmodule

// ### gtm_top_sva.sv
// bus handshake checks for the timer register slave
`timescale 1ns/1ps
module gtm_top_sva import gtm_pkg::*; (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // write channels
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read channels
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // a lost response would hang software forever
  write_answered_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid) else $error("write response missing");
  read_answered_a: assert property (rd_taken |-> ##[1:2] s_axi_rvalid) else $error("read response missing");
  bresp_held_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_held_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  write_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("second write open");
  read_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read open");
  bresp_retired_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("response repeated");
  unmapped_read_a: assert property (rd_taken ##0 s_axi_araddr == 8'h10 |-> ##[1:2]
    (s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)) else $error("unmapped read accepted");
  mapped_write_a: assert property (wr_taken ##0 s_axi_awaddr == OFF_CFG |-> ##[1:3]
    (s_axi_bvalid && s_axi_bresp == RESP_OKAY)) else $error("mapped write refused");
endmodule
bind gtm_top gtm_top_sva u_sva (
  .core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

// ### test_general_purpose_timer_modes.sv
// self-checking bench for the general purpose timer
`timescale 1ns/1ps
module test_general_purpose_timer_modes;
  import gtm_pkg::*;
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic [1:0] r;} gtm_row_type;
  logic        core_clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic        reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd_data, cap;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  capture_pin = 2'h0, s_axi_bresp, s_axi_rresp, pwm_out;
  int          errors = 0, comparisons = 0, hi_cnt;
  gtm_row_type rows[] = '{'{OFF_CFG, 0, 0, RST_ZERO, RESP_OKAY}, '{OFF_AILR, 0, 0, RST_ILR_A, RESP_OKAY},
    '{OFF_BILR, 0, 0, RST_ILR_B, RESP_OKAY}, '{OFF_AMATCH, 0, 0, RST_ILR_A, RESP_OKAY},
    '{OFF_BMATCH, 0, 0, RST_ILR_B, RESP_OKAY}, '{OFF_AVAL, 0, 0, RST_ILR_A, RESP_OKAY},
    '{OFF_BVAL, 0, 0, RST_ILR_B, RESP_OKAY}, '{OFF_RIS, 0, 0, RST_ZERO, RESP_OKAY},
    '{OFF_IMR, 0, 0, RST_ZERO, RESP_OKAY}, '{OFF_APR, 1, 32'h3, 32'h3, RESP_OKAY},
    '{OFF_ICR, 1, MASK32, RST_ZERO, RESP_OKAY}, '{8'h10, 1, 32'h1, RST_ZERO, RESP_SLVERR}};

  gtm_top DUT (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capture_pin, .pwm_out, .irq);

  task automatic cmp_word(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_resp(string n, logic [1:0] e, logic [1:0] g);
    cmp_word(n, {30'h0, e}, {30'h0, g});
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // write address and data offered together, each released when taken
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = RESP_OKAY);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp_resp("bresp", r, s_axi_bresp);
  endtask
  task automatic rd(logic [7:0] a, logic [1:0] r = RESP_OKAY);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd_data = s_axi_rdata;
    cmp_resp("rresp", r, s_axi_rresp);
  endtask
  task automatic chk(logic [7:0] a, logic [31:0] e, logic [1:0] r = RESP_OKAY);
    rd(a, r);
    cmp_word($sformatf("reg %h", a), e, rd_data);
  endtask
  // slow toggles leave room for the two-flop synchroniser and edge detect
  task automatic tog(int i);
    @(posedge core_clk);
    capture_pin[i] <= !capture_pin[i];
    repeat (6) @(posedge core_clk);
  endtask
  task automatic count_hi(int n, int e);
    hi_cnt = 0;
    repeat (n) begin
      @(posedge core_clk);
      hi_cnt += (pwm_out[1] === 1'b1);
    end
    cmp_word("pwm high cycles", e, hi_cnt);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = !core_clk;
  end
  initial begin
    #300us;
    errors++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].r);
      chk(rows[i].a, rows[i].e, rows[i].r);
    end
    $display("test register table done");
    wr(OFF_CFG, CFG_32);
    wr(OFF_AMODE, MODE_ONESHOT);
    wr(OFF_AILR, 32'h14);
    wr(OFF_IMR, 32'h1);
    wr(OFF_CTL, 32'h1);
    for (int k = 0; k < 300 && irq !== 1'b1; k++) @(posedge core_clk);
    cmp_word("irq", 1, irq);
    chk(OFF_RIS, 32'h1);
    chk(OFF_MIS, 32'h1);
    chk(OFF_CTL, 32'h0);
    wr(OFF_ICR, 32'h1);
    chk(OFF_RIS, 32'h0);
    cmp_word("irq", 0, irq);
    wr(OFF_IMR, 32'h0);
    wr(OFF_AMODE, MODE_PERIODIC);
    wr(OFF_AILR, 32'h8);
    wr(OFF_CTL, 32'h1);
    repeat (30) @(posedge core_clk);
    wr(OFF_ICR, 32'h1);
    repeat (20) @(posedge core_clk);
    chk(OFF_RIS, 32'h1);
    cmp_word("irq", 0, irq);
    chk(OFF_CTL, 32'h1);
    wr(OFF_CTL, 32'h0);
    wr(OFF_ICR, 32'h1);
    $display("test one-shot and periodic done");
    wr(OFF_CFG, CFG_SPLIT);
    wr(OFF_AMODE, MODE_ONESHOT);
    wr(OFF_AILR, 32'h8);
    wr(OFF_CTL, 32'h1);
    repeat (15) @(posedge core_clk);
    chk(OFF_RIS, 32'h0);
    repeat (30) @(posedge core_clk);
    chk(OFF_RIS, 32'h1);
    wr(OFF_ICR, 32'h1);
    $display("test prescaler done");
    wr(OFF_CFG, CFG_32);
    wr(OFF_AILR, 32'h0);
    wr(OFF_CFG, CFG_RTC);
    wr(OFF_AMATCH, 32'h3);
    wr(OFF_IMR, 32'h8);
    wr(OFF_CTL, 32'h11);
    repeat (6) tog(0);
    chk(OFF_AVAL, 32'h3);
    wr(OFF_ICR, 32'h8);
    chk(OFF_RIS, 32'h8);
    cmp_word("irq", 1, irq);
    repeat (2) tog(0);
    chk(OFF_AVAL, 32'h0);
    wr(OFF_CTL, 32'h0);
    $display("test real-time counter done");
    wr(OFF_CFG, CFG_SPLIT);
    wr(OFF_BMODE, MODE_CAPTURE);
    wr(OFF_CTL, 32'hC00);
    wr(OFF_BILR, 32'hA);
    wr(OFF_BMATCH, 32'h6);
    wr(OFF_IMR, 32'h200);
    wr(OFF_CTL, 32'hD00);
    repeat (3) tog(1);
    chk(OFF_BVAL, 32'h7);
    cmp_word("irq", 0, irq);
    repeat (3) tog(1);
    chk(OFF_BVAL, 32'hA);
    chk(OFF_CTL, 32'hC00);
    chk(OFF_MIS, 32'h200);
    wr(OFF_ICR, 32'h200);
    chk(OFF_RIS, 32'h0);
    $display("test edge count done");
    wr(OFF_AMODE, 32'h7);
    wr(OFF_CTL, 32'h4);
    wr(OFF_AILR, 32'h3E8);
    wr(OFF_IMR, 32'h4);
    wr(OFF_CTL, 32'h5);
    tog(0);
    chk(OFF_RIS, 32'h0);
    tog(0);
    rd(OFF_AVAL);
    cap = rd_data;
    cmp_word("capture range", 1, cap < 32'h3E8);
    repeat (10) @(posedge core_clk);
    chk(OFF_AVAL, cap);
    chk(OFF_MIS, 32'h4);
    wr(OFF_ICR, 32'h4);
    wr(OFF_AILR, 32'h5);
    repeat (2) tog(0);
    rd(OFF_AVAL);
    cmp_word("capture after reload", 1, rd_data <= 32'h5);
    wr(OFF_CTL, 32'h0);
    wr(OFF_ICR, MASK32);
    $display("test edge timing done");
    wr(OFF_BMODE, 32'hA);
    wr(OFF_BILR, 32'h9);
    wr(OFF_BMATCH, 32'h2);
    wr(OFF_CTL, 32'h100);
    count_hi(100, 70);
    wr(OFF_CTL, 32'h0);
    wr(OFF_BILR, 32'h9);
    wr(OFF_CTL, 32'h4100);
    count_hi(100, 30);
    wr(OFF_BILR, 32'h13);
    count_hi(202, 30);
    chk(OFF_RIS, 32'h0);
    $display("test pwm done");
    // reset again in mid-run with the inverted output low
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    cmp_word("pwm in reset", 0, pwm_out);
    reset_n <= 1'b1;
    chk(OFF_CTL, RST_ZERO);
    chk(OFF_BILR, RST_ILR_B);
    $display("test second reset done");
    stop_test();
  end
endmodule
